/* burst_if.sv */
// burst address step request and answer between the port and its sequencer
`timescale 1ns/10ps
interface burst_if;
    logic [1:0] base;
    logic [1:0] count;
    logic interleaved;
    logic [1:0] low;
    modport seq (input base, input count, input interleaved, output low);
    modport user (output base, output count, output interleaved, input low);
endinterface

/* burst_seq.sv */
// low address bits of a burst in linear or interleaved order
`timescale 1ns/10ps
module burst_seq (
    burst_if.seq bus
);
    import sram_port_pkg::*;

    // interleaved order xors the count in, linear order adds it with wrap
    always_comb begin
        if (bus.interleaved) begin
            bus.low = bus.base ^ bus.count; // [RL13]
        end else begin
            bus.low = 2'(bus.base + bus.count); // [RL12]
        end
    end
endmodule

/* sram_ctrl_model.sv */
// controller side model: write data lanes and the sleep tie-off
`timescale 1ns/10ps
module sram_ctrl_model (
    input wire logic clk,
    input wire logic drive,
    input wire logic nap,
    input wire logic [35:0] wd,
    output logic [31:0] data_in,
    output logic [3:0] parity_in,
    output logic sleep_request
);
    logic [35:0] held = '0;
    // ==========
    // sleep line grounded unless a nap is commanded
    assign sleep_request = nap;
    // write data in its data phase, a changing pattern once released
    assign {parity_in, data_in} = drive ? wd : ~held;
    always @(posedge clk) held <= {parity_in, data_in};
endmodule

/* sram_port.sv */
// pipelined synchronous burst sram: clock gating, sleep, data and parity lanes
`timescale 1ns/10ps
module sram_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clock_gate_n,
    input wire logic sleep_request,
    input wire logic output_enable_n,
    input wire logic burst_order,
    input wire logic select_low_first,
    input wire logic select_high,
    input wire logic select_low_third,
    input wire logic write_n,
    input wire logic adv_load_n,
    input wire logic [sram_port_pkg::ADDR_W-1:0] addr,
    input wire logic [sram_port_pkg::LANES-1:0] byte_lane_write_n,
    input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
    output logic [sram_port_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [sram_port_pkg::LANES-1:0] parity_in,
    output logic [sram_port_pkg::LANES-1:0] parity_out,
    output logic parity_oe,
    output logic asleep
);
    import sram_port_pkg::*;

    //==========================================================
    // limitations
    //==========================================================
    // pad pull-down on sleep and pull-up on the strap sit in the pads
    // output enable and sleep are asynchronous: two flops, so a change
    // reaches the lanes three edges later
    // strap is resynchronised all the time; change it only while deselected
    // sleep drops pending accesses; deselect before asking for it
    // the edge that sees sleep still stores a landing write
    // a write landing on the word being read is passed straight through

    //==========================================================
    // state
    //==========================================================
    // op1 is the access taken at the last ungated edge, op2 the one
    // before it, whose write data is on the lanes now
    typedef struct packed {
        logic sleep_meta;
        logic sleep_sync;
        logic oe_meta;
        logic oe_sync;
        logic order_meta;
        logic order_sync;
        power_e power;
        op_s op1;
        op_s op2;
        logic drive;
        logic [DATA_W-1:0] rd_data;
        logic [LANES-1:0] rd_parity;
        logic lanes_oe;
    } state_s;

    // lanes float and the strap reads interleaved until the pins are seen
    localparam state_s ST_RST = '{
        sleep_meta: 1'b0,
        sleep_sync: 1'b0,
        oe_meta: 1'b1,
        oe_sync: 1'b1,
        order_meta: 1'b1,
        order_sync: 1'b1,
        power: ST_AWAKE,
        op1: OP_RST,
        op2: OP_RST,
        drive: 1'b0,
        rd_data: '0,
        rd_parity: '0,
        lanes_oe: 1'b0
    };

    state_s st;
    state_s next_st;
    burst_if burst ();
    logic edge_ok;
    logic selected;
    logic wr_en;
    logic [DATA_W-1:0] rd_word;
    logic [LANES-1:0] rd_par;

    //==========================================================
    // burst sequencer
    //==========================================================
    burst_seq u_burst (
        .bus(burst.seq)
    );

    // next burst step from the running access
    assign burst.base = st.op1.base;
    assign burst.count = 2'(st.op1.cnt + BURST_STEP);
    assign burst.interleaved = st.order_sync; // [RL12] [RL13]

    //==========================================================
    // qualifiers
    //==========================================================
    // an edge counts only when ungated and awake
    assign edge_ok = !clock_gate_n && (st.power == ST_AWAKE); // [RL1]
    // three-way select, sampled on the edge
    assign selected = !select_low_first && select_high && !select_low_third; // [RL14]
    // write completes two edges after its command
    assign wr_en = edge_ok && st.op2.valid && st.op2.write; // [RL16]

    //==========================================================
    // storage, one array per byte lane with its parity bit
    //==========================================================
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W:0] lane_mem [0:DEPTH-1];
            logic bypass;
            logic [LANE_W:0] rd_cell;

            // lane stores data byte and parity under its own select
            always_ff @(posedge clk) begin
                if (wr_en && !st.op2.lane_n[g]) begin // [RL11] [RL15]
                    lane_mem[st.op2.addr] <= {parity_in[g], data_in[g*LANE_W +: LANE_W]}; // [RL7]
                end
            end

            // same word written at this edge with this lane enabled
            assign bypass = wr_en && !st.op2.lane_n[g] && (st.op2.addr == st.op1.addr); // [RL8] [RL11]

            // read path of this lane, the landing byte wins over the stale word
            assign rd_cell = bypass ? {parity_in[g], data_in[g*LANE_W +: LANE_W]} : lane_mem[st.op1.addr];
            assign rd_word[g*LANE_W +: LANE_W] = rd_cell[LANE_W-1:0];
            assign rd_par[g] = rd_cell[LANE_W];
        end
    endgenerate

    //==========================================================
    // next state
    //==========================================================
    always_comb begin
        next_st = st;
        // pins from outside the clock pass two flops
        next_st.sleep_meta = sleep_request; // [RL5]
        next_st.sleep_sync = st.sleep_meta;
        next_st.oe_meta = output_enable_n;
        next_st.oe_sync = st.oe_meta;
        next_st.order_meta = burst_order;
        next_st.order_sync = st.order_meta;

        // power state follows the synchronised sleep request
        case (st.power)
            ST_AWAKE: begin
                if (st.sleep_sync) begin
                    next_st.power = ST_ASLEEP; // [RL3]
                end
            end
            ST_ASLEEP: begin
                if (!st.sleep_sync) begin
                    next_st.power = ST_AWAKE;
                end
            end
            default: begin
                next_st.power = ST_AWAKE;
            end
        endcase

        // sleep wins over any command
        if (st.power == ST_ASLEEP || st.sleep_sync) begin
            // pending accesses are dropped, storage untouched
            next_st.op1 = OP_RST; // [RL3]
            next_st.op2 = OP_RST;
            next_st.drive = 1'b0;
        end else if (edge_ok) begin
            // the older access moves on to its data phase
            next_st.op2 = st.op1;
            if (!adv_load_n) begin
                // load a new access or a deselect
                next_st.op1.valid = selected; // [RL14]
                next_st.op1.write = !write_n;
                next_st.op1.addr = addr;
                next_st.op1.lane_n = byte_lane_write_n; // [RL15]
                next_st.op1.base = addr[1:0];
                next_st.op1.cnt = BURST_CNT_RST;
            end else if (st.op1.valid) begin
                // advance the burst, keeping its direction
                // chip selects and write request are ignored on an advance
                next_st.op1.cnt = burst.count;
                next_st.op1.addr = {st.op1.addr[ADDR_W-1:2], burst.low}; // [RL12] [RL13]
                next_st.op1.lane_n = byte_lane_write_n;
            end
            // read data of the address sampled at the command edge
            if (st.op1.valid && !st.op1.write) begin
                next_st.rd_data = rd_word; // [RL8]
                next_st.rd_parity = rd_par; // [RL11]
            end
            // float during write data, while deselected and on the first select
            next_st.drive = st.op1.valid && !st.op1.write; // [RL10]
        end
        // gated edges fall through with accesses and read data held [RL2]

        // output enable acts on every edge, gated or not
        next_st.lanes_oe = next_st.drive && !st.oe_sync && (next_st.power == ST_AWAKE); // [RL9]
    end

    //==========================================================
    // state register
    //==========================================================
    // single state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    //==========================================================
    // outputs
    //==========================================================
    // outputs straight from flops
    assign data_out = st.rd_data;
    assign parity_out = st.rd_parity;
    assign data_oe = st.lanes_oe; // [RL9]
    assign parity_oe = st.lanes_oe; // [RL11]
    // one-hot power code, bit 1 set only while asleep
    assign asleep = st.power[1];
endmodule

/* sram_port_monitor.sv */
// assertion checker for the sram data port pins
`timescale 1ns/10ps
module sram_port_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clock_gate_n,
    input wire logic sleep_request,
    input wire logic output_enable_n,
    input wire logic select_low_first,
    input wire logic select_high,
    input wire logic select_low_third,
    input wire logic write_n,
    input wire logic adv_load_n,
    input wire logic [sram_port_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic [sram_port_pkg::LANES-1:0] parity_out,
    input wire logic parity_oe,
    input wire logic asleep
);
    import sram_port_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic go;
    logic sel;
    // accepted load edge and chip select decode
    assign go = !clock_gate_n && !adv_load_n && !asleep && !sleep_request;
    assign sel = !select_low_first && select_high && !select_low_third;
    // ==========
    // assertions
    AST_GATE_HOLD: assert property (clock_gate_n |=> $stable({parity_out, data_out}))
        else $error("gated edge moved read data");
    AST_OE_OFF: assert property (output_enable_n [*3] |=> !data_oe)
        else $error("drive while output enable high");
    AST_WR_FLOAT: assert property (go && sel && !write_n ##1 !clock_gate_n |=> !data_oe)
        else $error("drive in write data phase");
    AST_DESEL_FLOAT: assert property (go && !sel ##1 !clock_gate_n |=> !data_oe)
        else $error("drive after deselect");
    AST_READ_DRIVE: assert property (!output_enable_n [*2] ##0 go && sel && write_n ##1 !clock_gate_n |=> data_oe)
        else $error("read not driven");
    AST_PAR_OE: assert property (parity_oe == data_oe)
        else $error("parity drive differs from data drive");
    AST_SLEEP_IN: assert property ((sleep_request && !clock_gate_n) [*3] |=> asleep)
        else $error("sleep not entered");
    AST_SLEEP_QUIET: assert property (asleep |-> !data_oe)
        else $error("drive while asleep");
    // main scenarios
    cover property (go && sel && write_n ##1 clock_gate_n);
    cover property (go && sel && !write_n ##2 !clock_gate_n);
    cover property (asleep);
endmodule

/* sram_port_pkg.sv */
// constants and types shared by the synchronous sram data port
//==========================================================
// What the document requires
// RL1: edges act only while clock gate low
// RL2: gating stretches cycle, holds state, no deselect
// RL3: sleep request enters sleep, contents kept
// RL4: controller holds sleep request low normally
// RL5: sleep request pad pulls down when open
// RL6: system ties sleep request to ground; the controller drives it from nap
// RL7: write data captured on rising edge
// RL8: read drives data of sampled address
// RL9: lanes drive only with output enable low
// RL10: float on write data, after deselect, deselected
// RL11: parity bits follow their byte lane selects
// RL12: strap low gives linear burst order
// RL13: strap high or open gives interleaved order
// RL14: selected when first, third low, second high
// RL15: byte selects with write request pick bytes
// RL16: write data latched second edge after command
// RL17: controller releases data before read cycles
package sram_port_pkg;
    localparam int ADDR_W = 17;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [1:0] BURST_CNT_RST = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;

    typedef enum logic [1:0] {
        ST_AWAKE = 2'b01,
        ST_ASLEEP = 2'b10
    } power_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_n;
        logic [1:0] base;
        logic [1:0] cnt;
    } op_s;

    localparam op_s OP_RST = '{valid: 1'b0, write: 1'b0, addr: '0, lane_n: 4'hf, base: 2'h0, cnt: 2'h0};
endpackage

/* tb_sram_port.sv */
// self-checking bench of the sram data port against a behavioural memory
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_sram_port;
    import sram_port_pkg::*;
    logic clk = 0, sys_rst = 1, clock_gate_n = 0, output_enable_n = 0, burst_order = 0;
    logic select_high = 0, write_n = 1, adv_load_n = 0, drive = 0, nap = 0;
    logic select_low_first = 0, select_low_third = 0;
    logic data_oe, parity_oe, asleep, sleep_request;
    logic [ADDR_W-1:0] addr = '0;
    logic [LANES-1:0] byte_lane_write_n = 4'hf, parity_in, parity_out;
    logic [DATA_W-1:0] data_in, data_out;
    logic [35:0] wd = '0;
    logic [35:0] mem [int];
    int err_count = 0, n_tests = 0, b;
    // ==========
    // clock, design and controller
    initial forever #12.5 clk = ~clk;
    sram_port dut (.clk(clk), .sys_rst(sys_rst), .clock_gate_n(clock_gate_n), .sleep_request(sleep_request),
        .output_enable_n(output_enable_n), .burst_order(burst_order), .select_low_first(select_low_first),
        .select_high(select_high), .select_low_third(select_low_third), .write_n(write_n), .adv_load_n(adv_load_n),
        .addr(addr), .byte_lane_write_n(byte_lane_write_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .parity_in(parity_in), .parity_out(parity_out), .parity_oe(parity_oe), .asleep(asleep));
    sram_ctrl_model partner (.clk(clk), .drive(drive), .nap(nap), .wd(wd), .data_in(data_in),
        .parity_in(parity_in), .sleep_request(sleep_request));
    // one burst: load, advances, deselect; mode 1 random lanes, mode 2 gated mid-burst
    task automatic op(input bit w, input int a, input int beats, input int mode);
        int lo [4];
        logic [3:0] ln [4];
        int k, key, sp;
        for (int c = 0; c < beats + 2; c++) begin
            @(negedge clk);
            if (mode == 2 && c == 1) begin
                clock_gate_n = 1;
                adv_load_n = 1'($urandom);
                repeat (3) @(negedge clk);
                clock_gate_n = 0;
            end
            adv_load_n = (c != 0) && (c < beats);
            sp = $urandom % 3;
            select_low_first = (c >= beats) && (sp == 0);
            select_high = (c < beats) || (sp != 1);
            select_low_third = (c >= beats) && (sp == 2);
            write_n = !w;
            addr = ADDR_W'(a);
            byte_lane_write_n = (mode == 1) ? 4'($urandom) : 4'h0;
            wd = 36'({$urandom, $urandom});
            drive = w && c >= 2;
            if (c == 1) `CHK("float first cycle", 1'b0, data_oe)
            if (c < beats) begin
                lo[c] = burst_order ? ((a ^ c) & 3) : ((a + c) & 3);
                ln[c] = byte_lane_write_n;
            end
            if (c >= 2) begin
                k = c - 2;
                key = (a & 32'h1fffc) | lo[k];
                if (w) begin
                    for (int i = 0; i < 4; i++) begin
                        if (!ln[k][i]) mem[key][8*i +: 8] = wd[8*i +: 8];
                        if (!ln[k][i]) mem[key][32+i] = wd[32+i];
                    end
                end else `CHK("read data", mem[key], {parity_out, data_out})
                `CHK("drive enable", !w && !output_enable_n, data_oe)
            end
        end
        // one more deselected edge: lanes must have let go
        @(negedge clk);
        `CHK("float after deselect", 1'b0, data_oe)
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========
    // main sequence
    initial begin
        void'($urandom(32'hd39f));
        repeat (16) @(negedge clk);
        sys_rst = 0;
        for (int o = 0; o < 2; o++) begin
            burst_order = o[0];
            repeat (3) @(negedge clk);
            b = $urandom & 32'h1ffff;
            op(1, b, 4, 0);
            op(1, b ^ 2, 4, 1);
            op(0, b ^ 1, 4, 2);
            op(0, b ^ 3, 4, 0);
            $display("burst order %0d test done", o);
        end
        output_enable_n = 1;
        repeat (3) @(negedge clk);
        op(0, b, 2, 0);
        output_enable_n = 0;
        $display("output enable test done");
        nap = 1;
        repeat (8) @(negedge clk);
        `CHK("asleep", 1'b1, asleep)
        nap = 0;
        repeat (8) @(negedge clk);
        `CHK("awake", 1'b0, asleep)
        op(0, b, 4, 0);
        $display("sleep test done");
        give_verdict;
    end
    // watchdog
    initial begin
        #100000;
        err_count++;
        give_verdict;
    end
endmodule
bind sram_port sram_port_monitor mon (.clk(clk), .sys_rst(sys_rst), .clock_gate_n(clock_gate_n),
    .sleep_request(sleep_request), .output_enable_n(output_enable_n), .select_low_first(select_low_first),
    .select_high(select_high), .select_low_third(select_low_third), .write_n(write_n), .adv_load_n(adv_load_n),
    .data_out(data_out), .data_oe(data_oe), .parity_out(parity_out), .parity_oe(parity_oe), .asleep(asleep));
